// file: include/ssr_pkg.sv
// Constants and types for the sense data responder
`default_nettype none
package ssr_pkg;
   localparam logic [7:0] OP_SENSE      = 8'h03;  // Sense request opcode
   localparam logic [7:0] OP_INQUIRY    = 8'h12;  // Inquiry opcode
   localparam logic [4:0] SENSE_LEN     = 5'h1a;  // Total sense bytes (26)
   localparam logic [4:0] ZERO_ALLOC    = 5'h04;  // Bytes sent for count zero
   localparam logic [4:0] CTR_MIN_ALLOC = 5'h13;  // Bytes needed for clear (19)
   localparam logic [7:0] ADD_LEN       = 8'h12;  // Bytes after byte 07 (18)
   localparam logic [2:0] ERR_CLASS     = 3'h7;   // Extended error class
   localparam logic [3:0] ERR_CODE      = 4'h0;   // Error code
   localparam int         CLR_BIT       = 7;      // CDB byte 05 clear bit
   // Sense key encodings
   localparam logic [3:0] KEY_NONE      = 4'h0;
   localparam logic [3:0] KEY_NOT_READY = 4'h2;
   localparam logic [3:0] KEY_MEDIUM    = 4'h3;
   localparam logic [3:0] KEY_HARDWARE  = 4'h4;
   localparam logic [3:0] KEY_ILLEGAL   = 4'h5;
   localparam logic [3:0] KEY_ATTENTION = 4'h6;
   localparam logic [3:0] KEY_PROTECT   = 4'h7;
   // Status byte values
   localparam logic [7:0] ST_GOOD       = 8'h00;
   localparam logic [7:0] ST_CONFLICT   = 8'h18;
   // Avalon register offsets (byte addresses)
   localparam logic [5:0] REG_STATUS    = 6'h00;  // Event status, read clears
   localparam logic [5:0] REG_MASK      = 6'h04;  // Interrupt mask
   localparam logic [5:0] REG_COUNTER   = 6'h08;  // Error counter
   localparam logic [5:0] REG_SAVED     = 6'h0c;  // Saved owner and valid
   // Status bit positions
   localparam int EV_SERVED   = 0;  // Sense data served
   localparam int EV_CONFLICT = 1;  // Reservation conflict answered
   localparam int EV_CLEARED  = 2;  // Counter cleared
   localparam int EV_DISCARD  = 3;  // Saved sense discarded
   localparam int EV_W        = 4;
   // Responder states, Gray from idle through send to done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_DONE = 2'b11
   } ssr_state_t;
endpackage : ssr_pkg
`default_nettype wire

// file: core/ssr_sense_responder.sv
// Sense request responder with saved sense, counter and Avalon registers
// Function
// - Opcode 03h returns 26-byte extended sense
// - Check Condition builds and saves sense data
// - Owner's other commands except inquiry discard saved sense
// - Allocation zero sends exactly four bytes
// - Send lesser of allocation and 26
// - Clear bit resets error counter bytes 16-18
// - Clear needs 19 bytes, after completion
// - Foreign clear while reserved gets conflict
// - Foreign plain request still gets sense
// - Vendor spare bit has no effect
// - Valid bit marks information bytes valid
// - Byte 00 holds class 7, code 0
// - Length, ASC, ASCQ, counter at fixed bytes
// - Byte 02 bit 7 flags filemark
// - Bit 6 flags tape start/end, write end only
// - Bit 5 flags block length mismatch
// - Sense key uses defined encodings
`default_nettype none
module ssr_sense_responder (
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Command strobe with decoded CDB fields
   input  wire logic        cmdValid,
   input  wire logic [2:0]  cmdInitiator,
   input  wire logic [7:0]  cmdOpcode,
   input  wire logic [7:0]  cmdAlloc,
   input  wire logic [7:0]  cmdControl,
   // Reservation state from the unit
   input  wire logic        resvActive,
   input  wire logic [2:0]  resvOwner,
   // Check Condition report with its sense content
   input  wire logic        checkValid,
   input  wire logic [2:0]  checkInitiator,
   input  wire logic        infoValid,
   input  wire logic [31:0] infoBytes,
   input  wire logic [3:0]  senseKey,
   input  wire logic        filemark_seen,
   input  wire logic        logical_tape_start,
   input  wire logic        logical_tape_end,
   input  wire logic        writeMode,
   input  wire logic        block_length_mismatch,
   input  wire logic [7:0]  ascCode,
   input  wire logic [7:0]  ascqCode,
   input  wire logic [23:0] flagBytes,
   input  wire logic [23:0] tapeRemaining,
   // Error counter increment
   input  wire logic        errorInc,
   // Data In byte stream
   input  wire logic        dataReady,
   output logic             dataValid,
   output logic [7:0]       dataByte,
   output logic             dataLast,
   // Command completion with status byte
   output logic             statusValid,
   output logic [7:0]       statusByte,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq
);
   import ssr_pkg::*;

   ssr_state_t  state_q;          // Responder state
   logic        saved_q;          // Saved sense present
   logic [2:0]  owner_q;          // Initiator the sense belongs to
   logic [7:0]  img_q [0:25];     // Saved sense image
   logic [23:0] counter_q;        // Read/write error counter
   logic [4:0]  limit_q;          // Bytes to send
   logic [4:0]  idx_q;            // Current byte index
   logic        clrPend_q;        // Counter clear after completion
   logic [EV_W-1:0] evt_q;        // Sticky event status
   logic [EV_W-1:0] mask_q;       // Interrupt mask
   logic        ackPend_q;        // Bus access answered next cycle
   logic        foreign_q;        // Requester does not own saved sense

   // Request decode
   logic        isSense, isOwner, clrReq, conflict, discard;
   logic [4:0]  allocLen, sendLen;
   logic        lastByte, dataFire;
   logic        rdStatus;
   logic [EV_W-1:0] evSet;

   always_comb begin
      isSense  = cmdValid && cmdOpcode == OP_SENSE;
      isOwner  = saved_q && owner_q == cmdInitiator;
      clrReq   = cmdControl[CLR_BIT];
      conflict = isSense && clrReq && resvActive
                 && resvOwner != cmdInitiator;
      discard  = cmdValid && isOwner && cmdOpcode != OP_SENSE
                 && cmdOpcode != OP_INQUIRY;
      // Clamp allocation to the available bytes
      if (cmdAlloc == 8'h00) begin
         allocLen = ZERO_ALLOC;
      end else if (cmdAlloc >= {3'h0, SENSE_LEN}) begin
         allocLen = SENSE_LEN;
      end else begin
         allocLen = cmdAlloc[4:0];
      end
      sendLen  = allocLen;
      dataFire = dataValid && dataReady;
      lastByte = idx_q == limit_q - 5'h01;
      rdStatus = avs_read && ackPend_q && avs_address == REG_STATUS;
   end

   // Responder sequence
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q   <= ST_IDLE;
         limit_q   <= 5'h00;
         idx_q     <= 5'h00;
         clrPend_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (isSense && !conflict) begin
                  state_q   <= ST_SEND;
                  limit_q   <= sendLen;
                  idx_q     <= 5'h00;
                  clrPend_q <= clrReq && allocLen >= CTR_MIN_ALLOC;
               end
            end
            ST_SEND: begin
               if (dataFire) begin
                  idx_q <= idx_q + 5'h01;
                  if (lastByte) begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               state_q   <= ST_IDLE;
               clrPend_q <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Byte to send; a foreign requester sees only the no-sense image
   function automatic logic [7:0] pick(input logic [4:0] i,
                                       input logic       plain);
      logic [7:0] b;
      b = img_q[i];
      if (plain) begin
         if (i == 5'h00) begin
            b = {1'b0, ERR_CLASS, ERR_CODE};
         end else if (i == 5'h02) begin
            b = {4'h0, KEY_NONE};
         end else if (i == 5'h07) begin
            b = ADD_LEN;
         end else if (i < 5'h10 || i > 5'h12) begin
            // Counter bytes stay live, the rest read zero
            b = 8'h00;
         end
      end
      return b;
   endfunction : pick

   // Data In outputs from flip-flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dataValid <= 1'b0;
         dataByte  <= 8'h00;
         dataLast  <= 1'b0;
         foreign_q <= 1'b0;
      end else if (state_q == ST_IDLE && isSense && !conflict) begin
         dataValid <= 1'b1;
         dataByte  <= pick(5'h00, !isOwner);
         dataLast  <= sendLen == 5'h01;
         foreign_q <= !isOwner;
      end else if (dataFire) begin
         dataValid <= !lastByte;
         dataByte  <= lastByte ? 8'h00 : pick(idx_q + 5'h01, foreign_q);
         dataLast  <= idx_q + 5'h02 == limit_q;
      end
   end

   // Status byte at completion or conflict
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         statusValid <= 1'b0;
         statusByte  <= ST_GOOD;
      end else begin
         statusValid <= 1'b0;
         if (state_q == ST_IDLE && conflict) begin
            statusValid <= 1'b1;
            statusByte  <= ST_CONFLICT;
         end else if (state_q == ST_SEND && dataFire && lastByte) begin
            statusValid <= 1'b1;
            statusByte  <= ST_GOOD;
         end
      end
   end

   // Saved sense image build and discard
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         saved_q <= 1'b0;
         owner_q <= 3'h0;
         for (int i = 0; i < 26; i++) begin
            img_q[i] <= 8'h00;
         end
      end else if (checkValid) begin
         saved_q  <= 1'b1;
         owner_q  <= checkInitiator;
         img_q[0] <= {infoValid, ERR_CLASS, ERR_CODE};
         img_q[1] <= 8'h00;
         img_q[2] <= {filemark_seen,
                      writeMode ? logical_tape_end
                                : (logical_tape_start
                                   || logical_tape_end),
                      block_length_mismatch, 1'b0,
                      senseKey};
         img_q[3] <= infoBytes[31:24];
         img_q[4] <= infoBytes[23:16];
         img_q[5] <= infoBytes[15:8];
         img_q[6] <= infoBytes[7:0];
         img_q[7] <= ADD_LEN;
         for (int i = 8; i < 12; i++) begin
            img_q[i] <= 8'h00;
         end
         img_q[12] <= ascCode;
         img_q[13] <= ascqCode;
         img_q[14] <= 8'h00;
         img_q[15] <= 8'h00;
         img_q[19] <= flagBytes[23:16];
         img_q[20] <= flagBytes[15:8];
         img_q[21] <= flagBytes[7:0];
         img_q[22] <= 8'h00;
         img_q[23] <= tapeRemaining[23:16];
         img_q[24] <= tapeRemaining[15:8];
         img_q[25] <= tapeRemaining[7:0];
      end else if (discard) begin
         saved_q <= 1'b0;
         for (int i = 0; i < 26; i++) begin
            img_q[i] <= 8'h00;
         end
      end else if (state_q == ST_IDLE && isSense && !saved_q) begin
         // No saved condition: no-sense image
         img_q[0] <= {1'b0, ERR_CLASS, ERR_CODE};
         img_q[2] <= {4'h0, KEY_NONE};
         img_q[7] <= ADD_LEN;
      end
      // Counter bytes load the live counter at each sense request seen in idle, conflict or not
      if (state_q == ST_IDLE && isSense) begin
         img_q[16] <= counter_q[23:16];
         img_q[17] <= counter_q[15:8];
         img_q[18] <= counter_q[7:0];
      end
   end

   // Error counter, cleared only after completion
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         counter_q <= 24'h000000;
      end else if (state_q == ST_DONE && clrPend_q) begin
         counter_q <= 24'h000000;
      end else if (errorInc && counter_q != 24'hffffff) begin
         counter_q <= counter_q + 24'h000001;
      end
   end

   // Events; a new event wins over a read clear
   always_comb begin
      evSet = '0;
      evSet[EV_SERVED]   = state_q == ST_DONE;
      evSet[EV_CONFLICT] = state_q == ST_IDLE && conflict;
      evSet[EV_CLEARED]  = state_q == ST_DONE && clrPend_q;
      evSet[EV_DISCARD]  = discard;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         evt_q <= '0;
      end else begin
         evt_q <= (rdStatus ? '0 : evt_q) | evSet;
      end
   end

   // Mask register write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_q <= '0;
      end else if (avs_write && ackPend_q && avs_address == REG_MASK) begin
         mask_q <= avs_writedata[EV_W-1:0];
      end
   end

   // Interrupt level from flip-flop
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |((evt_q & ~(rdStatus ? evt_q : '0) | evSet) & mask_q);
      end
   end

   // Avalon: one wait cycle, answer on the second
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ackPend_q       <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         ackPend_q       <= (avs_read || avs_write) && !ackPend_q;
         avs_waitrequest <= !((avs_read || avs_write) && !ackPend_q);
         if (avs_read && !ackPend_q) begin
            unique case (avs_address)
               REG_STATUS:  avs_readdata <= {28'h0, evt_q};
               REG_MASK:    avs_readdata <= {28'h0, mask_q};
               REG_COUNTER: avs_readdata <= {8'h00, counter_q};
               REG_SAVED:   avs_readdata <= {28'h0, saved_q, owner_q};
               default:     avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule : ssr_sense_responder
`default_nettype wire

// file: verif/ssr_initiator_model.sv
// Initiator model: takes Data In bytes, stalling at random
`default_nettype none
module ssr_initiator_model (
   input  wire logic       clk,
   input  wire logic       slow,
   input  wire logic       dataValid,
   input  wire logic [7:0] dataByte,
   output logic            dataReady
);
   timeunit 1ns;
   timeprecision 1ns;
   integer     seed = 90;  // Fixed stall seed
   logic [7:0] rxQ[$];     // Bytes taken this transfer
   initial dataReady = 1'b0;
   // Take a byte on ready; slow mode stalls about three cycles in four
   always @(posedge clk) begin
      if (dataValid && dataReady)
         rxQ.push_back(dataByte);
      dataReady <= !slow || ($random(seed) % 4 == 0);
   end
endmodule : ssr_initiator_model
`default_nettype wire

// file: verif/ssr_sense_responder_chk.sv
// Port checker for the sense responder, bound to the core
`default_nettype none
module ssr_sense_responder_chk
   import ssr_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       cmdValid,
   input wire logic [2:0] cmdInitiator,
   input wire logic [7:0] cmdOpcode,
   input wire logic [7:0] cmdAlloc,
   input wire logic [7:0] cmdControl,
   input wire logic       resvActive,
   input wire logic [2:0] resvOwner,
   input wire logic       dataReady,
   input wire logic       dataValid,
   input wire logic [7:0] dataByte,
   input wire logic       dataLast,
   input wire logic       statusValid,
   input wire logic [7:0] statusByte
);
   logic       isSense;  // Sense request while idle
   logic       refuse;   // Foreign clear while reserved
   logic       go;       // Request that sends data
   logic [4:0] cnt_q;    // Bytes taken so far
   logic [4:0] want_q;   // Bytes owed this transfer
   assign isSense = cmdValid && !dataValid && cmdOpcode == OP_SENSE;
   assign refuse = isSense && cmdControl[CLR_BIT] && resvActive
                   && resvOwner != cmdInitiator;
   assign go = isSense && !refuse;
   // Count taken bytes and latch the owed length
   always_ff @(posedge clk) begin
      if (!rst_b || isSense)
         cnt_q <= 5'h00;
      else if (dataValid && dataReady)
         cnt_q <= cnt_q + 5'h01;
      if (isSense)
         want_q <= (cmdAlloc == 8'h00) ? ZERO_ALLOC
                 : (cmdAlloc > 8'h1a) ? SENSE_LEN : cmdAlloc[4:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_hold; dataValid && !dataReady |=> $stable(dataByte); endproperty
   a_hold: assert property (p_hold) else $error("byte changed");
   property p_head; go |=> dataValid && dataByte[6:0] == 7'h70; endproperty
   a_head: assert property (p_head) else $error("bad byte 0");
   property p_refuse; refuse |=> statusValid && !dataValid
      && statusByte == ST_CONFLICT; endproperty
   a_refuse: assert property (p_refuse) else $error("no conflict");
   property p_good; dataValid && dataReady && dataLast |=> statusValid
      && statusByte == ST_GOOD; endproperty
   a_good: assert property (p_good) else $error("no good status");
   property p_pulse; statusValid |=> !statusValid; endproperty
   a_pulse: assert property (p_pulse) else $error("status held");
   property p_last; dataValid && dataLast |-> cnt_q == want_q - 5'h01;
   endproperty
   a_last: assert property (p_last) else $error("bad count");
   property p_mid; dataValid && !dataLast |-> cnt_q < want_q - 5'h01;
   endproperty
   a_mid: assert property (p_mid) else $error("overrun");
   property p_quiet; dataValid |-> !statusValid; endproperty
   a_quiet: assert property (p_quiet) else $error("early status");
   cover property (go && cmdAlloc == 8'h00);
   cover property (refuse);
   cover property (go && cmdControl[7] && cmdAlloc > 8'h12);
endmodule : ssr_sense_responder_chk
bind ssr_sense_responder ssr_sense_responder_chk chk (.*);
`default_nettype wire

// file: verif/scsi_sense_data_responder_bench.sv
// Self-checking bench for the sense data responder
`default_nettype none
module scsi_sense_data_responder_bench;
   import ssr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, cmdValid, resvActive, checkValid, infoValid, writeMode;
   logic filemark_seen, logical_tape_start, logical_tape_end, errorInc;
   logic block_length_mismatch, dataReady, dataValid, dataLast, statusValid;
   logic avs_read, avs_write, avs_waitrequest, irq, slow, own, irqA;
   logic [2:0] cmdInitiator, resvOwner, checkInitiator, owner;
   logic [3:0] senseKey;
   logic [5:0] avs_address;
   logic [7:0] cmdOpcode, cmdAlloc, cmdControl, ascCode, ascqCode;
   logic [7:0] dataByte, statusByte;
   logic [23:0] flagBytes, tapeRemaining, ctr;
   logic [31:0] infoBytes, avs_writedata, avs_readdata, q;
   logic [3:0] keyTab[7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
   logic [7:0] allocTab[6] = '{8'h00, 8'h01, 8'h04, 8'h12, 8'h13, 8'h1a};
   integer seed = 90;
   int n_fail = 0;
   int total_checks = 0;
   ssr_sense_responder DUT (.*);
   ssr_initiator_model model (.*);
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog against a hang
   initial begin
      #3000000;
      n_fail++;
      print_verdict();
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic cmd(input logic [2:0] who, input logic [7:0] op, al, ctl);
      {cmdInitiator, cmdOpcode, cmdAlloc, cmdControl} <= {who, op, al, ctl};
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
   endtask : cmd
   task automatic bump();
      errorInc <= 1'b1;
      @(posedge clk);
      errorInc <= 1'b0;
      @(posedge clk);
      if (ctr != 24'hffffff) ctr++;
   endtask : bump
   // Check Condition with random sense content
   task automatic cond(input logic [2:0] who, input logic [3:0] key);
      {checkInitiator, senseKey} <= {who, key};
      {infoValid, filemark_seen, logical_tape_start, logical_tape_end,
       writeMode, block_length_mismatch, ascCode, ascqCode}
         <= 22'($random(seed));
      {infoBytes, flagBytes, tapeRemaining}
         <= 80'({$random(seed), $random(seed), $random(seed)});
      checkValid <= 1'b1;
      @(posedge clk);
      checkValid <= 1'b0;
      own = 1'b1;
      owner = who;
   endtask : cond
   // Register access, held until waitrequest low
   task automatic avs(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      int i;
      {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 99);
      if (i >= 99) n_fail++;
      rd = avs_readdata;
      {avs_read, avs_write} <= 2'b00;
      @(posedge clk);
   endtask : avs
   // Expected sense byte i for an initiator
   function automatic logic [7:0] want(input logic [2:0] who, input int i);
      if (i > 15 && i < 19)
         return ctr[8*(18-i) +: 8];
      if (!own || who != owner)
         return (i == 0) ? 8'h70 : (i == 7) ? ADD_LEN : 8'h00;
      case (i)
         0: return {infoValid, ERR_CLASS, ERR_CODE};
         2: return {filemark_seen, writeMode ? logical_tape_end
                    : (logical_tape_start | logical_tape_end),
                    block_length_mismatch, 1'b0, senseKey};
         3, 4, 5, 6: return infoBytes[8*(6-i) +: 8];
         7: return ADD_LEN;
         12: return ascCode;
         13: return ascqCode;
         19, 20, 21: return flagBytes[8*(21-i) +: 8];
         23, 24, 25: return tapeRemaining[8*(25-i) +: 8];
         default: return 8'h00;
      endcase
   endfunction : want
   // Sense request, compare bytes, status and counter
   task automatic sense(input logic [2:0] who, input logic [7:0] al, ctl);
      int n, i;
      logic conf;
      logic [7:0] b0;
      conf = ctl[CLR_BIT] && resvActive && resvOwner != who;
      n = (al == 8'h00) ? 4 : (al > 8'h1a) ? 26 : int'(al);
      b0 = want(who, 0);
      model.rxQ.delete();
      cmd(who, OP_SENSE, al, ctl);
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (statusValid !== 1'b1 && i < 999);
      check(statusByte, conf ? ST_CONFLICT : ST_GOOD);
      check(model.rxQ.size(), conf ? 0 : n);
      for (i = 0; i < model.rxQ.size(); i++)
         if ((i < 19 || (own && who == owner)) && (b0[7] || i < 3 || i > 6))
            check(model.rxQ[i], want(who, i));
      if (!conf && ctl[CLR_BIT] && n >= 19) ctr = 24'h0;
      @(posedge clk);
      avs(1'b0, REG_COUNTER, 32'h0, q);
      check(q, {8'h00, ctr});
      $display("sense test from %0d alloc %0d done", who, al);
   endtask : sense
   // Main sequence
   initial begin
      {rst_b, cmdValid, resvActive, checkValid, errorInc, avs_read, avs_write,
       slow, own, ctr, resvOwner, owner, avs_address, avs_writedata} = '0;
      {cmdInitiator, cmdOpcode, cmdAlloc, cmdControl, checkInitiator,
       senseKey, infoValid, filemark_seen, logical_tape_start, writeMode,
       logical_tape_end, block_length_mismatch, ascCode, ascqCode,
       infoBytes, flagBytes, tapeRemaining} = '0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      sense(3'h2, 8'h00, 8'h00);
      for (int k = 0; k < 14; k++) begin
         repeat (k % 3) bump();
         slow <= k[0];
         cond(3'(k), keyTab[k % 7]);
         sense(3'(k), (k < 6) ? allocTab[k] : 8'($random(seed)), 8'h00);
      end
      cond(3'h1, 4'h3);
      cmd(3'h1, OP_INQUIRY, 8'h00, 8'h00);
      repeat (4) @(posedge clk);
      cmd(3'h4, 8'h08, 8'h00, 8'h00);
      repeat (4) @(posedge clk);
      sense(3'h1, 8'h1a, 8'h00);
      sense(3'h6, 8'h1a, 8'h00);
      cmd(3'h1, 8'h08, 8'h00, 8'h00);
      own = 1'b0;
      repeat (4) @(posedge clk);
      sense(3'h1, 8'h1a, 8'h00);
      repeat (5) bump();
      sense(3'h2, 8'h12, 8'h80);
      sense(3'h2, 8'h13, 8'h40);
      sense(3'h2, 8'h13, 8'hc0);
      {resvActive, resvOwner} <= 4'hd;
      repeat (3) bump();
      sense(3'h2, 8'h1a, 8'h80);
      sense(3'h2, 8'h1a, 8'h00);
      sense(3'h5, 8'h1a, 8'h80);
      resvActive <= 1'b0;
      avs(1'b1, REG_MASK, 32'h0, q);
      avs(1'b0, REG_STATUS, 32'h0, q);
      sense(3'h2, 8'h04, 8'h00);
      irqA = irq;
      avs(1'b0, REG_STATUS, 32'h0, q);
      check(q[EV_SERVED], 1'b1);
      avs(1'b0, REG_STATUS, 32'h0, q);
      check(q[3:0], 4'h0);
      avs(1'b1, REG_MASK, 32'hf, q);
      sense(3'h2, 8'h04, 8'h00);
      check(irq ^ irqA, 1'b1);
      avs(1'b0, REG_STATUS, 32'h0, q);
      avs(1'b1, REG_COUNTER, 32'h5, q);
      avs(1'b0, REG_COUNTER, 32'h0, q);
      check(q, {8'h00, ctr});
      avs(1'b0, 6'h10, 32'h0, q);
      check(q, 32'h0);
      check(irq, 1'b0);
      $display("register test done");
      print_verdict();
   end
endmodule : scsi_sense_data_responder_bench
`default_nettype wire
